// ### src/ssw_defines.svh
// Constants for the supply supervisor and watchdog reset block
`ifndef SSW_DEFINES_SVH
`define SSW_DEFINES_SVH

`define SSW_CLK_PERIOD_NS 10
// Manual reset least low time, in ns
`define SSW_MR_MIN_NS 1000
// Manual glitch rejection, in ns
`define SSW_MR_GLITCH_NS 100
// Least strobe pulse, in ns
`define SSW_STROBE_MIN_NS 50
// Manual filter must accept 1 us: round down
`define SSW_MR_FILT_CYC (`SSW_MR_MIN_NS / `SSW_CLK_PERIOD_NS)
// Undervoltage dip filter, in ns
`define SSW_UV_FILT_NS 8000
`define SSW_UV_FILT_CYC (`SSW_UV_FILT_NS / `SSW_CLK_PERIOD_NS)
// Reset hold period, 140 ms minimum
`define SSW_HOLD_MS 140
`define SSW_HOLD_CYC (`SSW_HOLD_MS * 1000000 / `SSW_CLK_PERIOD_NS)
// Strobe timeout period, 1.6 s typical
`define SSW_TIMEOUT_MS 1600
`define SSW_TIMEOUT_CYC (`SSW_TIMEOUT_MS * 1000000 / `SSW_CLK_PERIOD_NS)
// Host strobe interval, in cycles, a quarter of the timeout
`define SSW_HOST_PERIOD_CYC (`SSW_TIMEOUT_CYC / 4)
// Host strobe high time, in cycles
`define SSW_HOST_PULSE_CYC 10

`endif

// ### src/ssw_filter.sv
// Level filter: output follows input once stable for a count of cycles
`timescale 1ns/1ps
module ssw_filter #(
    parameter int unsigned COUNT = 100,
    parameter logic INIT = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic din_i,
    output logic dout_o
);
    localparam int unsigned CW = $clog2(COUNT + 1);
    logic meta_r;
    logic sync_r;
    logic [CW-1:0] cnt_r;

    // --------------------------------------------------------------
    // Synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= din_i;
            sync_r <= meta_r;
        end
    end

    // --------------------------------------------------------------
    // Stability counter
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            dout_o <= INIT;
        end else if (sync_r == dout_o) begin
            cnt_r <= '0;
        end else if (cnt_r >= CW'(COUNT - 1)) begin
            cnt_r <= '0;
            dout_o <= sync_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule : ssw_filter

// ### src/ssw_link_if.sv
// Link between the supervisor and the processor
`timescale 1ns/1ps
interface ssw_link_if;
    logic reset_n;
    logic reset;
    logic strobe_out;
    logic strobe_oe;
    logic strobe_drive;
    logic strobe_float;
    modport supervisor (output reset_n, output reset, input strobe_out, input strobe_float);
    modport processor (input reset_n, input reset, output strobe_drive, output strobe_oe);
    // Strobe is tristate; float flag models the window comparator
    assign strobe_out = strobe_oe ? strobe_drive : 1'b0;
    assign strobe_float = ~strobe_oe;
endinterface : ssw_link_if

// ### src/ssw_pkg.sv
// Types shared by the supervisor and the testbench
package ssw_pkg;
    typedef enum logic [1:0] {
        SSW_CAUSE_NONE,
        SSW_CAUSE_SUPPLY,
        SSW_CAUSE_MANUAL,
        SSW_CAUSE_WATCHDOG
    } ssw_cause_t;
endpackage : ssw_pkg

// ### src/ssw_processor.sv
// Processor end: strobes the watchdog while out of reset
`timescale 1ns/1ps
`include "ssw_defines.svh"
module ssw_processor #(
    parameter int unsigned PERIOD_CYC = `SSW_HOST_PERIOD_CYC,
    parameter int unsigned PULSE_CYC = `SSW_HOST_PULSE_CYC
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic STROBE_EN_I,
    input wire logic STROBE_FLOAT_I,
    output logic IN_RESET_O,
    ssw_link_if.processor LINK
);
    localparam int unsigned PW = $clog2(PERIOD_CYC + 1);
    logic [PW-1:0] cnt_r;
    logic strobe_r;

    // --------------------------------------------------------------
    // Strobe generator
    // --------------------------------------------------------------
    // Brief high pulse once per period keeps input current low
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I | ~LINK.reset_n) begin
            cnt_r <= '0;
            strobe_r <= 1'b0;
        end else if (cnt_r == PW'(PERIOD_CYC - 1)) begin
            cnt_r <= '0;
            strobe_r <= STROBE_EN_I;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == PW'(PULSE_CYC - 1)) begin
                strobe_r <= 1'b0;
            end
        end
    end

    assign LINK.strobe_drive = strobe_r;
    assign LINK.strobe_oe = ~STROBE_FLOAT_I;
    assign IN_RESET_O = ~LINK.reset_n;
endmodule : ssw_processor

// ### src/ssw_supervisor.sv
// Supervisor end: combines supply, manual and watchdog causes into reset
`timescale 1ns/1ps
`include "ssw_defines.svh"
module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter int unsigned HOLD_CYC = `SSW_HOLD_CYC,
    parameter int unsigned TIMEOUT_CYC = `SSW_TIMEOUT_CYC,
    parameter int unsigned MR_FILT_CYC = `SSW_MR_FILT_CYC,
    parameter int unsigned UV_FILT_CYC = `SSW_UV_FILT_CYC
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic UNDERVOLTAGE_I,
    input wire logic MANUAL_RESET_N_I,
    output ssw_cause_t CAUSE_O,
    ssw_link_if.supervisor LINK
);
    localparam int unsigned HW = $clog2(HOLD_CYC + 1);
    localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);
    // Bit positions in the watchdog pin synchroniser bank
    localparam int unsigned PIN_STROBE = 0;
    localparam int unsigned PIN_FLOAT = 1;
    localparam int unsigned PIN_N = 2;
    // Idle levels: strobe low, watchdog disabled until the pin is seen driven
    localparam logic [PIN_N-1:0] PIN_IDLE = 2'h2;

    // Reset sequencer: a live cause, then the hold count, then run
    typedef enum logic [1:0] {
        SSW_SEQ_RUN,
        SSW_SEQ_CAUSE,
        SSW_SEQ_HOLD
    } ssw_seq_t;

    logic manual_n;
    logic uv;
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_meta_r;
    logic [PIN_N-1:0] pin_sync_r;
    logic strobe_sync;
    logic strobe_prev_r;
    logic float_sync;
    logic strobe_edge;
    logic wd_enabled;
    logic wd_clear;
    logic wd_fire;
    logic [TW-1:0] wd_r;
    logic cause_live;
    logic reset_cause;
    ssw_cause_t cause_now;
    ssw_cause_t cause_r;
    ssw_seq_t seq_r;
    logic [HW-1:0] hold_r;
    logic hold_done;
    logic reset_r;

    // --------------------------------------------------------------
    // Cause decoding
    // --------------------------------------------------------------
    // Supply outranks manual and manual outranks the watchdog, so the
    // reported cause names the condition that lasts the longest
    function automatic ssw_cause_t cause_pick(input logic uv_f, input logic manual_n_f, input logic fire_f);
        ssw_cause_t pick;
        pick = SSW_CAUSE_NONE;
        if (uv_f) begin
            pick = SSW_CAUSE_SUPPLY;
        end else if (!manual_n_f) begin
            pick = SSW_CAUSE_MANUAL;
        end else if (fire_f) begin
            pick = SSW_CAUSE_WATCHDOG;
        end
        return pick;
    endfunction : cause_pick

    // --------------------------------------------------------------
    // Input conditioning
    // --------------------------------------------------------------
    // Filter length covers glitch rejection and debounce together
    ssw_filter #(.COUNT(MR_FILT_CYC), .INIT(1'b1)) u_mr_filt (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .din_i(MANUAL_RESET_N_I),
        .dout_o(manual_n)
    );

    // Supply is seen only after the dip has lasted the filter time
    ssw_filter #(.COUNT(UV_FILT_CYC), .INIT(1'b0)) u_uv_filt (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .din_i(UNDERVOLTAGE_I),
        .dout_o(uv)
    );

    // --------------------------------------------------------------
    // Watchdog pin synchronisers
    // --------------------------------------------------------------
    // Float flag and strobe level pass the same two stages, so a strobe
    // change and the end of a float are seen in step
    assign pin_raw = {LINK.strobe_float, LINK.strobe_out};

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            pin_meta_r <= PIN_IDLE;
            pin_sync_r <= PIN_IDLE;
        end else begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
        end
    end

    assign strobe_sync = pin_sync_r[PIN_STROBE];
    assign float_sync = pin_sync_r[PIN_FLOAT];

    // Previous level resets to the idle low level, so no false edge
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            strobe_prev_r <= 1'b0;
        end else begin
            strobe_prev_r <= strobe_sync;
        end
    end

    // A 50 ns pulse spans several 10 ns edges, so both edges are seen
    assign strobe_edge = strobe_sync ^ strobe_prev_r;

    // --------------------------------------------------------------
    // Watchdog timer
    // --------------------------------------------------------------
    assign cause_live = uv | ~manual_n;
    // An undriven pin disconnects expiry from the reset path entirely
    assign wd_enabled = ~float_sync;
    assign wd_clear = reset_r | cause_live | ~wd_enabled;
    assign wd_fire = (wd_r == TW'(TIMEOUT_CYC - 1)) & wd_enabled;

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            wd_r <= '0;
        end else if (wd_clear) begin
            wd_r <= '0;
        end else if (strobe_edge) begin
            wd_r <= '0;
        end else if (wd_fire) begin
            wd_r <= '0;
        end else begin
            wd_r <= wd_r + 1'b1;
        end
    end

    // --------------------------------------------------------------
    // Reset sequencer
    // --------------------------------------------------------------
    assign cause_now = cause_pick(uv, manual_n, wd_fire);
    assign reset_cause = (cause_now != SSW_CAUSE_NONE);
    assign hold_done = (hold_r == '0);

    // A new cause restarts the sequence from any state
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            seq_r <= SSW_SEQ_HOLD;
        end else if (reset_cause) begin
            seq_r <= SSW_SEQ_CAUSE;
        end else begin
            unique case (seq_r)
                SSW_SEQ_RUN: begin
                    seq_r <= SSW_SEQ_RUN;
                end
                SSW_SEQ_CAUSE, SSW_SEQ_HOLD: begin
                    seq_r <= hold_done ? SSW_SEQ_RUN : SSW_SEQ_HOLD;
                end
                // Unused code: fall back to holding reset
                default: begin
                    seq_r <= SSW_SEQ_HOLD;
                end
            endcase
        end
    end

    // Hold count reloads for as long as a cause lasts, so the period
    // is measured from the end of the cause
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            hold_r <= HW'(HOLD_CYC);
        end else if (reset_cause) begin
            hold_r <= HW'(HOLD_CYC);
        end else if (!hold_done) begin
            hold_r <= hold_r - 1'b1;
        end
    end

    // Reset leaves from its own flop so the processor never sees a
    // glitch from the state decode; it is asserted from power-up
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            reset_r <= 1'b1;
        end else if (reset_cause) begin
            reset_r <= 1'b1;
        end else if (seq_r != SSW_SEQ_RUN && hold_done) begin
            reset_r <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Cause record
    // --------------------------------------------------------------
    // Power-up counts as a supply event
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            cause_r <= SSW_CAUSE_SUPPLY;
        end else if (reset_cause) begin
            cause_r <= cause_now;
        end else if (seq_r == SSW_SEQ_RUN) begin
            cause_r <= SSW_CAUSE_NONE;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign LINK.reset_n = ~reset_r;
    assign LINK.reset = reset_r;
    assign CAUSE_O = cause_r;
endmodule : ssw_supervisor

// ### tb/ssw_link_sva.sv
// Assertions on the link between supervisor and processor
`timescale 1ns/1ps
module ssw_link_sva #(
    parameter int unsigned HOLD_CYC = 50,
    parameter int unsigned TIMEOUT_CYC = 200
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic reset_n,
    input wire logic reset,
    input wire logic strobe_out,
    input wire logic strobe_oe,
    input wire logic strobe_drive
);
    int unsigned low_cnt_r;
    int unsigned idle_cnt_r;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    always_ff @(posedge REF_CLK_I) begin
        low_cnt_r <= (RST_I || reset_n) ? 0 : low_cnt_r + 1;
    end
    // Slack in the bound covers the strobe synchroniser
    always_ff @(posedge REF_CLK_I) begin
        idle_cnt_r <= (RST_I || !reset_n || !strobe_oe || strobe_out != $past(strobe_out)) ? 0 : idle_cnt_r + 1;
    end
    a_outputs_complement: assert property (reset == !reset_n) else $error("reset pair disagrees");
    a_hold_min: assert property ($rose(reset_n) |-> low_cnt_r >= HOLD_CYC) else $error("hold too short");
    a_fire_stands: assert property ($fell(reset_n) |-> !reset_n [*8]) else $error("reset pulse short");
    a_watchdog_bound: assert property (idle_cnt_r <= TIMEOUT_CYC + 6) else $error("no expiry");
    a_release_quiet: assert property ($rose(reset_n) |=> reset_n [*8]) else $error("early refire");
    a_strobe_brief: assert property ($rose(strobe_drive) |-> ##[1:11] !strobe_drive) else $error("long pulse");
    a_strobe_idle_reset: assert property (!reset_n [*3] |-> !strobe_out) else $error("strobe in reset");
    a_float_quiet: assert property (!strobe_oe [*8] ##0 reset_n |=> reset_n) else $error("fired floating");
    c_fire: cover property ($fell(reset_n));
    c_strobe: cover property ($rose(strobe_drive));
    c_float: cover property (!strobe_oe && reset_n);
endmodule : ssw_link_sva

// ### tb/testbench.sv
// Self-checking bench for the supervisor and processor pair
`timescale 1ns/1ps
module testbench;
    import ssw_pkg::*;
    localparam int HOLD = 50;
    localparam int TMO = 200;
    logic clk = 1'b0, rst = 1'b1, uv = 1'b0, mr_n = 1'b1, en = 1'b1, flt = 1'b0;
    logic in_rst;
    ssw_cause_t cause;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    ssw_link_if link ();
    ssw_supervisor #(.HOLD_CYC(HOLD), .TIMEOUT_CYC(TMO), .UV_FILT_CYC(20)) i_ssw_supervisor (.REF_CLK_I(clk),
        .RST_I(rst), .UNDERVOLTAGE_I(uv), .MANUAL_RESET_N_I(mr_n), .CAUSE_O(cause), .LINK(link));
    ssw_processor #(.PERIOD_CYC(40), .PULSE_CYC(5)) i_ssw_processor (.REF_CLK_I(clk), .RST_I(rst),
        .STROBE_EN_I(en), .STROBE_FLOAT_I(flt), .IN_RESET_O(in_rst), .LINK(link));
    ssw_link_sva #(.HOLD_CYC(HOLD), .TIMEOUT_CYC(TMO)) i_ssw_link_sva (.REF_CLK_I(clk), .RST_I(rst),
        .reset_n(link.reset_n), .reset(link.reset), .strobe_out(link.strobe_out), .strobe_oe(link.strobe_oe),
        .strobe_drive(link.strobe_drive));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(string what, logic [1:0] exp, logic [1:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // Negative lo: reset must keep its level for hi cycles
    task automatic wl(logic v, int lo, int hi, string what);
        int n;
        n = 0;
        while (link.reset_n !== v && n <= hi) begin
            step(1);
            n++;
        end
        chk(what, 2'h1, (lo < 0) ? 2'(n > hi) : 2'(n >= lo && n <= hi));
    endtask : wl
    task automatic t_manual();
        mr_n = 1'b0;
        step(10);
        mr_n = 1'b1;
        step(5);
        mr_n = 1'b0;
        step(60);
        mr_n = 1'b1;
        wl(1'b0, -1, 150, "manual glitch");
        en = 1'b0;
        mr_n = 1'b0;
        wl(1'b0, 100, 106, "manual assert");
        step(1);
        chk("manual cause", SSW_CAUSE_MANUAL, cause);
        chk("processor view", 2'h1, 2'(in_rst));
        wl(1'b1, -1, 80, "manual held");
        mr_n = 1'b1;
        wl(1'b1, HOLD, HOLD + 110, "manual release");
        wl(1'b0, TMO - 2, TMO + 12, "timer restart");
        step(1);
        chk("watchdog cause", SSW_CAUSE_WATCHDOG, cause);
        wl(1'b1, HOLD - 2, HOLD + 4, "expiry hold");
        en = 1'b1;
    endtask : t_manual
    task automatic t_supply();
        uv = 1'b1;
        step(15);
        uv = 1'b0;
        wl(1'b0, -1, 60, "supply dip");
        uv = 1'b1;
        wl(1'b0, 20, 26, "supply assert");
        step(1);
        chk("supply cause", SSW_CAUSE_SUPPLY, cause);
        wl(1'b1, -1, 80, "supply held");
        uv = 1'b0;
        wl(1'b1, HOLD, HOLD + 30, "supply release");
    endtask : t_supply
    task automatic t_float();
        en = 1'b0;
        flt = 1'b1;
        wl(1'b0, -1, 2 * TMO, "floating strobe");
        flt = 1'b0;
    endtask : t_float
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        step(3);
        rst = 1'b0;
        wl(1'b1, HOLD, HOLD + 150, "power-up release");
        step(1);
        chk("idle cause", SSW_CAUSE_NONE, cause);
        wl(1'b0, -1, 3 * TMO, "strobed run");
        t_manual();
        t_supply();
        t_float();
        tally_and_finish();
    end
endmodule : testbench
